//--- hw/overlay_pkg.sv
package overlay_pkg;

  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] IDX_BPP_SEL = 8'h70;
  localparam logic [7:0] IDX_EFFECTS = 8'h71;
  localparam logic [7:0] IDX_START_LOW = 8'h7c;
  localparam logic [7:0] IDX_START_MID = 8'h7d;
  localparam logic [7:0] IDX_START_TOP = 8'h7e;
  localparam logic [7:0] IDX_OFFSET_LOW = 8'h80;
  localparam logic [7:0] IDX_OFFSET_HIGH = 8'h81;
  localparam logic [7:0] IDX_HSTART_LOW = 8'h84;
  localparam logic [7:0] IDX_HSTART_HIGH = 8'h85;
  localparam logic [7:0] IDX_VEND_HIGH = 8'h91;
  localparam logic [7:0] IDX_STATUS = 8'h92;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int EFFECTS_ENABLE_BIT = 4;
  localparam int STATUS_PENDING_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // rotation and colour depth codes
  // ****************************************
  localparam logic [1:0] ROT_0 = 2'b00;
  localparam logic [1:0] ROT_90 = 2'b01;
  localparam logic [1:0] ROT_180 = 2'b10;
  localparam logic [1:0] ROT_270 = 2'b11;
  localparam logic [2:0] BPP_1 = 3'h0;
  localparam logic [2:0] BPP_16 = 3'h4;
  localparam logic [2:0] SHIFT_AT_1BPP = 3'h5;

  typedef enum logic [1:0] {
    COMMIT_IDLE = 2'b00,
    COMMIT_ARMED = 2'b01
  } commit_state_type;

  typedef struct packed {
    logic [7:0] start_low;
    logic [7:0] start_mid;
    logic start_top;
    logic [7:0] offset_low;
    logic [1:0] offset_high;
    logic [7:0] hstart_low;
    logic [1:0] hstart_high;
    logic [1:0] vend_high;
    logic enable;
    logic [1:0] rotation;
    logic [2:0] bpp;
  } soft_regs_type;

  typedef struct packed {
    logic enable;
    logic [16:0] start_addr;
    logic [9:0] line_offset;
    logic [1:0] rotation;
    logic [9:0] hstart;
    logic [14:0] hstart_pixels;
    logic hstart_in_lines;
  } overlay_cfg_type;

endpackage

//--- hw/overlay_hstart_scale.sv
`timescale 1ns/10ps
`default_nettype none
module overlay_hstart_scale (
  input wire logic [9:0] hstart,
  input wire logic [1:0] rotation,
  input wire logic [2:0] bpp,
  output logic [14:0] pixels,
  output logic in_lines
);

  logic [2:0] shift;

  always_comb begin
    shift = overlay_pkg::SHIFT_AT_1BPP - bpp;
    pixels = 15'h0000;
    in_lines = 1'b0;
    if (rotation[0]) begin
      // 90 and 270: the field walks the rotated axis, one line per unit
      in_lines = 1'b1;
      pixels = {5'h00, hstart};
    end else if (bpp <= overlay_pkg::BPP_16) begin
      // reserved depth codes give no offset rather than a wild one
      pixels = 15'({5'h00, hstart} << shift);
    end
  end

endmodule
`default_nettype wire

//--- hw/overlay_window_regs.sv
`timescale 1ns/10ps
`default_nettype none
module overlay_window_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [9:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [9:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic vert_nondisplay,
  output overlay_pkg::overlay_cfg_type overlay_cfg
);

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  // ****************************************
  // bus channel state
  // ****************************************
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [9:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_byte_r, w_byte_nxt;
  logic w_lane_r, w_lane_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  overlay_pkg::soft_regs_type regs_r, regs_nxt;
  logic [9:0] hstart_live_r, hstart_live_nxt;
  logic vend_written;
  logic [7:0] rd_byte;
  logic rd_hit;
  overlay_pkg::commit_state_type commit_r, commit_nxt;

  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    aw_addr_nxt = aw_addr_r;
    w_byte_nxt = w_byte_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    regs_nxt = regs_r;
    vend_written = 1'b0;
    if (awvalid && awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_held_nxt = 1'b1;
      w_byte_nxt = wdata[7:0];
      w_lane_nxt = wstrb[0];
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_held_r && w_held_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = overlay_pkg::RESP_OKAY;
      // only lane 0 carries data; unused bits of narrow fields are dropped
      if (aw_addr_r[9:2] == overlay_pkg::IDX_BPP_SEL) begin
        if (w_lane_r) regs_nxt.bpp = w_byte_r[2:0];
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_EFFECTS) begin
        if (w_lane_r) begin
          regs_nxt.enable = w_byte_r[overlay_pkg::EFFECTS_ENABLE_BIT];
          regs_nxt.rotation = w_byte_r[1:0];
        end
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_START_LOW) begin
        if (w_lane_r) regs_nxt.start_low = w_byte_r;
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_START_MID) begin
        if (w_lane_r) regs_nxt.start_mid = w_byte_r;
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_START_TOP) begin
        if (w_lane_r) regs_nxt.start_top = w_byte_r[0];
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_OFFSET_LOW) begin
        if (w_lane_r) regs_nxt.offset_low = w_byte_r;
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_OFFSET_HIGH) begin
        if (w_lane_r) regs_nxt.offset_high = w_byte_r[1:0];
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_HSTART_LOW) begin
        if (w_lane_r) regs_nxt.hstart_low = w_byte_r;
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_HSTART_HIGH) begin
        if (w_lane_r) regs_nxt.hstart_high = w_byte_r[1:0];
      end else if (aw_addr_r[9:2] == overlay_pkg::IDX_VEND_HIGH) begin
        if (w_lane_r) regs_nxt.vend_high = w_byte_r[1:0];
        vend_written = w_lane_r;
      end else if (aw_addr_r[9:2] != overlay_pkg::IDX_STATUS) begin
        bresp_nxt = overlay_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // read decode
  // ****************************************
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = overlay_pkg::REG_RESET;
    if (araddr[9:2] == overlay_pkg::IDX_BPP_SEL) begin
      rd_byte = {5'h00, regs_r.bpp};
    end else if (araddr[9:2] == overlay_pkg::IDX_EFFECTS) begin
      rd_byte = {3'h0, regs_r.enable, 2'b00, regs_r.rotation};
    end else if (araddr[9:2] == overlay_pkg::IDX_START_LOW) begin
      rd_byte = regs_r.start_low;
    end else if (araddr[9:2] == overlay_pkg::IDX_START_MID) begin
      rd_byte = regs_r.start_mid;
    end else if (araddr[9:2] == overlay_pkg::IDX_START_TOP) begin
      rd_byte = {7'h00, regs_r.start_top};
    end else if (araddr[9:2] == overlay_pkg::IDX_OFFSET_LOW) begin
      rd_byte = regs_r.offset_low;
    end else if (araddr[9:2] == overlay_pkg::IDX_OFFSET_HIGH) begin
      rd_byte = {6'h00, regs_r.offset_high};
    end else if (araddr[9:2] == overlay_pkg::IDX_HSTART_LOW) begin
      rd_byte = regs_r.hstart_low;
    end else if (araddr[9:2] == overlay_pkg::IDX_HSTART_HIGH) begin
      rd_byte = {6'h00, regs_r.hstart_high};
    end else if (araddr[9:2] == overlay_pkg::IDX_VEND_HIGH) begin
      rd_byte = {6'h00, regs_r.vend_high};
    end else if (araddr[9:2] == overlay_pkg::IDX_STATUS) begin
      rd_byte = {7'h00, commit_r == overlay_pkg::COMMIT_ARMED};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_byte};
      rresp_nxt = rd_hit ? overlay_pkg::RESP_OKAY : overlay_pkg::RESP_SLVERR;
    end
  end

  // ****************************************
  // position commit at vertical blanking
  // ****************************************
  logic vnd_prev_r, vnd_rise;
  assign vnd_rise = vert_nondisplay && !vnd_prev_r;

  always_comb begin
    commit_nxt = commit_r;
    hstart_live_nxt = hstart_live_r;
    case (commit_r)
      overlay_pkg::COMMIT_IDLE: begin
        if (vend_written) commit_nxt = overlay_pkg::COMMIT_ARMED;
      end
      overlay_pkg::COMMIT_ARMED: begin
        // a blanking edge seen with a fresh last write commits and stays armed for the next edge
        if (vnd_rise) begin
          hstart_live_nxt = {regs_r.hstart_high, regs_r.hstart_low};
          commit_nxt = vend_written ? overlay_pkg::COMMIT_ARMED : overlay_pkg::COMMIT_IDLE;
        end
      end
      default: commit_nxt = overlay_pkg::COMMIT_IDLE;
    endcase
  end

  logic [14:0] hs_pixels;
  logic hs_lines;
  overlay_pkg::overlay_cfg_type cfg_r, cfg_nxt;

  overlay_hstart_scale u_scale (
    .hstart(hstart_live_r),
    .rotation(regs_r.rotation),
    .bpp(regs_r.bpp),
    .pixels(hs_pixels),
    .in_lines(hs_lines)
  );

  always_comb begin
    cfg_nxt.enable = regs_r.enable;
    cfg_nxt.rotation = regs_r.rotation;
    // double-word units pass straight to the fetch logic
    cfg_nxt.start_addr = {regs_r.start_top, regs_r.start_mid, regs_r.start_low};
    cfg_nxt.line_offset = {regs_r.offset_high, regs_r.offset_low};
    // disabled window shows no position at all
    cfg_nxt.hstart = regs_r.enable ? hstart_live_r : 10'h000;
    cfg_nxt.hstart_pixels = regs_r.enable ? hs_pixels : 15'h0000;
    cfg_nxt.hstart_in_lines = regs_r.enable && hs_lines;
  end
  assign overlay_cfg = cfg_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 10'h000;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'b00;
      regs_r <= '0;
      hstart_live_r <= 10'h000;
      commit_r <= overlay_pkg::COMMIT_IDLE;
      vnd_prev_r <= 1'b0;
      cfg_r <= '0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      regs_r <= regs_nxt;
      hstart_live_r <= hstart_live_nxt;
      commit_r <= commit_nxt;
      vnd_prev_r <= vert_nondisplay;
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_commit_only_blank: assert property ($changed(hstart_live_r) |->
    $past(commit_r == overlay_pkg::COMMIT_ARMED && vnd_rise)) else $error("early commit");
  a_commit_arms: assert property (vend_written |=>
    commit_r == overlay_pkg::COMMIT_ARMED) else $error("commit not armed");
  a_disable_gate: assert property (!cfg_r.enable |->
    cfg_r.hstart_pixels == 15'h0000 && !cfg_r.hstart_in_lines) else $error("gate fail");
  a_step_1bpp: assert property (regs_r.enable && regs_r.rotation == overlay_pkg::ROT_0
    && regs_r.bpp == overlay_pkg::BPP_1 |=> cfg_r.hstart_pixels ==
    15'({5'h00, $past(hstart_live_r)} << 5)) else $error("1bpp step wrong");
  a_step_16bpp: assert property (regs_r.enable && regs_r.rotation == overlay_pkg::ROT_180
    && regs_r.bpp == overlay_pkg::BPP_16 |=> cfg_r.hstart_pixels ==
    15'({5'h00, $past(hstart_live_r)} << 1) && !cfg_r.hstart_in_lines) else $error("16bpp");
  a_rotated_lines: assert property (regs_r.enable && regs_r.rotation[0] |=>
    cfg_r.hstart_in_lines && cfg_r.hstart_pixels[9:0] == $past(hstart_live_r))
    else $error("rotated step wrong");
  a_start_join: assert property (##1 cfg_r.start_addr ==
    $past({regs_r.start_top, regs_r.start_mid, regs_r.start_low})) else $error("start addr");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("rvalid dropped");

  c_commit: cover property (commit_r == overlay_pkg::COMMIT_ARMED ##[1:50] vnd_rise);
  c_write_resp: cover property (bvalid && bready && bresp == overlay_pkg::RESP_OKAY);
  c_bad_read: cover property (rvalid && rresp == overlay_pkg::RESP_SLVERR);
  c_rotated: cover property (cfg_r.enable && cfg_r.hstart_in_lines);

endmodule
`default_nettype wire

//--- testbench/axi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module axi_host_model (
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output logic [9:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [9:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // responses are always accepted at once
  assign bready = 1'b1;
  assign rready = 1'b1;
  initial begin
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
  end
  // ****************************************
  // bus cycles, entered just after a rising edge
  // ****************************************
  // released address and data lines flip (wstrb is left as it was) so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic s,
                    output logic [1:0] r);
    bit a;
    bit w;
    a = 0;
    w = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= {3'h0, s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      // each channel is let go at the very edge that takes it
      if (!a && awready) begin
        a = 1;
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~araddr;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
endmodule
`default_nettype wire

//--- testbench/overlay_window_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module overlay_window_regs_tb;
  logic aclk, aresetn, vert_nondisplay;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [9:0] awaddr, araddr, hv, prev;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  overlay_pkg::overlay_cfg_type overlay_cfg;
  int fail_count, total_checks;
  logic [7:0] idx [7] = '{overlay_pkg::IDX_START_LOW, overlay_pkg::IDX_START_MID,
    overlay_pkg::IDX_START_TOP, overlay_pkg::IDX_OFFSET_LOW, overlay_pkg::IDX_OFFSET_HIGH,
    overlay_pkg::IDX_HSTART_LOW, overlay_pkg::IDX_HSTART_HIGH};
  logic [7:0] msk [7] = '{8'hff, 8'hff, 8'h01, 8'hff, 8'h03, 8'hff, 8'h03};
  overlay_window_regs DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .vert_nondisplay, .overlay_cfg);
  axi_host_model h (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************************************
  // watchdog, about ten times the expected run
  // ****************************************
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    results();
  end
  initial begin
    aresetn = 1'b0;
    vert_nondisplay = 1'b0;
    fail_count = 0;
    total_checks = 0;
    prev = 10'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      h.rd(idx[i], d, r);
      chk(d, 32'h0);
    end
    for (int i = 0; i < 7; i++) begin
      h.wr(idx[i], 8'hc3 + 8'(i), 1'b1, r);
      chk(32'(r), 32'(overlay_pkg::RESP_OKAY));
      h.rd(idx[i], d, r);
      chk(d, {24'h0, (8'hc3 + 8'(i)) & msk[i]});
    end
    chk(32'(overlay_cfg.start_addr), 32'h1c4c3);
    chk(32'(overlay_cfg.line_offset), 32'h3c6);
    chk(32'(overlay_cfg.hstart), 32'h0);
    h.wr(overlay_pkg::IDX_START_LOW, 8'h11, 1'b0, r);
    chk(32'(r), 32'(overlay_pkg::RESP_OKAY));
    h.rd(overlay_pkg::IDX_START_LOW, d, r);
    chk(d, 32'hc3);
    h.wr(8'h3f, 8'h77, 1'b1, r);
    chk(32'(r), 32'(overlay_pkg::RESP_SLVERR));
    h.rd(8'h3f, d, r);
    chk({d[29:0], r}, {30'h0, overlay_pkg::RESP_SLVERR});
    // ****************************************
    // every rotation and depth, each through a commit
    // ****************************************
    for (int rot = 0; rot < 4; rot++) begin
      for (int b = 0; b < 5; b++) begin
        hv = 10'(b * 5 + rot + 1);
        h.wr(overlay_pkg::IDX_EFFECTS, 8'h10 | 8'(rot), 1'b1, r);
        h.wr(overlay_pkg::IDX_BPP_SEL, 8'(b), 1'b1, r);
        h.wr(overlay_pkg::IDX_HSTART_LOW, hv[7:0], 1'b1, r);
        h.wr(overlay_pkg::IDX_HSTART_HIGH, {6'h0, hv[9:8]}, 1'b1, r);
        chk(32'(overlay_cfg.hstart), 32'(prev));
        h.wr(overlay_pkg::IDX_VEND_HIGH, 8'h00, 1'b1, r);
        h.rd(overlay_pkg::IDX_STATUS, d, r);
        chk(d, 32'h1);
        vert_nondisplay <= 1'b1;
        repeat (4) @(posedge aclk);
        vert_nondisplay <= 1'b0;
        chk(32'(overlay_cfg.hstart), 32'(hv));
        chk(32'(overlay_cfg.hstart_pixels), rot[0] ? 32'(hv) : 32'(hv) << (5 - b));
        chk(32'(overlay_cfg.hstart_in_lines), 32'(rot[0]));
        chk(32'(overlay_cfg.rotation), 32'(rot));
        prev = hv;
      end
    end
    // reserved depth code gives no offset; status is read-only and idle after commit
    h.wr(overlay_pkg::IDX_EFFECTS, 8'h10, 1'b1, r);
    h.wr(overlay_pkg::IDX_BPP_SEL, 8'h05, 1'b1, r);
    h.rd(overlay_pkg::IDX_BPP_SEL, d, r);
    chk(d, 32'h5);
    chk(32'(overlay_cfg.hstart_pixels), 32'h0);
    chk(32'(overlay_cfg.hstart), 32'(prev));
    chk(32'(overlay_cfg.enable), 32'h1);
    h.wr(overlay_pkg::IDX_STATUS, 8'h01, 1'b1, r);
    chk(32'(r), 32'(overlay_pkg::RESP_OKAY));
    h.rd(overlay_pkg::IDX_STATUS, d, r);
    chk(d, 32'h0);
    h.rd(overlay_pkg::IDX_VEND_HIGH, d, r);
    chk(d, 32'h0);
    h.wr(overlay_pkg::IDX_EFFECTS, 8'h00, 1'b1, r);
    repeat (2) @(posedge aclk);
    chk(32'({overlay_cfg.hstart, overlay_cfg.hstart_pixels}), 32'h0);
    chk(32'(overlay_cfg.enable), 32'h0);
    // ****************************************
    // reset again in mid-run
    // ****************************************
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(overlay_cfg.start_addr), 32'h0);
    h.rd(overlay_pkg::IDX_HSTART_LOW, d, r);
    chk(d, 32'h0);
    results();
  end
endmodule
`default_nettype wire
